// >>> rtl/iobf_core.sv
// Decode and execute of indexed bit set and fill-ones operations
`timescale 1ns/100ps
module iobf_core
  import iobf_pkg::*;
#(
  parameter int ADDR_W = IOBF_ADDR_W
) (
  input wire logic REF_CLK,
  input wire logic RSTN,
  input wire logic CE,
  input wire logic INSTR_VALID,
  input wire logic [15:0] INSTR_WORD,
  input wire logic [ADDR_W-1:0] POINTER_REGISTER_TWO,
  input wire logic [7:0] MEM_RDATA,
  output logic [1:0] PHASE,
  output logic [ADDR_W-1:0] MEM_ADDR,
  output logic MEM_RD,
  output logic MEM_WR,
  output logic [7:0] MEM_WDATA,
  output logic OP_ACTIVE,
  output logic OP_ILLEGAL
);
  // Elaboration check: the offset is eight bits, so narrower would truncate
  if (ADDR_W < 8 || ADDR_W > 16) begin : g_addr_w_check
    $error("ADDR_W must lie between 8 and 16");
  end

  // Decode of a fetched word; used for both the latch and the checks
  function automatic iobf_op_type decode_op(input logic [15:0] w);
    if (w[15:12] == IOBF_SETB_OP && !w[8]) begin
      decode_op = IOBF_SETB;
    end else if (w[15:8] == IOBF_FILL_OP) begin
      decode_op = IOBF_FILL;
    end else begin
      decode_op = IOBF_NONE;
    end
  endfunction

  iobf_phase_type phase;
  iobf_op_type op_q, op_d;
  logic [ADDR_W-1:0] addr_q, addr_d;
  logic [2:0] bit_q, bit_d;
  logic [7:0] data_q, data_d;
  logic rd_q, rd_d, wr_q, wr_d, act_q, act_d, ill_q, ill_d;
  logic [7:0] ofs;

  iobf_phase_gen u_phase (
    .clk(REF_CLK),
    .rst_n(RSTN),
    .ce(CE),
    .phase(phase)
  );

  assign ofs = INSTR_WORD[7:0];

  // Next state per phase; the illegal flag is updated only in decode, the active flag in decode and last phase
  always_comb begin
    op_d = op_q;
    addr_d = addr_q;
    bit_d = bit_q;
    data_d = data_q;
    rd_d = 1'b0;
    wr_d = 1'b0;
    act_d = act_q;
    ill_d = ill_q;
    case (phase)
      IOBF_Q1: begin
        op_d = INSTR_VALID ? decode_op(INSTR_WORD) : IOBF_NONE;
        ill_d = INSTR_VALID && decode_op(INSTR_WORD) != IOBF_NONE
          && ofs > 8'(IOBF_OFS_MAX);
        if (ill_d) begin
          op_d = IOBF_NONE;
        end
        addr_d = POINTER_REGISTER_TWO + ADDR_W'(ofs);
        bit_d = INSTR_WORD[IOBF_BIT_MSB:IOBF_BIT_LSB];
        act_d = op_d != IOBF_NONE;
        // Read strobe issued for the read phase
        rd_d = op_d == IOBF_SETB;
      end
      IOBF_Q2: begin
        // Capture target byte returned during the read phase
        data_d = MEM_RDATA;
      end
      IOBF_Q3: begin
        case (op_q)
          IOBF_SETB: data_d = data_q | (8'h01 << bit_q);
          IOBF_FILL: data_d = IOBF_ONES;
          default: data_d = data_q;
        endcase
        // Write back strobe for last phase
        wr_d = op_q != IOBF_NONE;
      end
      default: begin
        act_d = 1'b0;
      end
    endcase
  end

  // State registers, frozen while the enable is low
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      op_q <= IOBF_NONE;
      addr_q <= '0;
      bit_q <= 3'h0;
      data_q <= IOBF_BYTE_RST;
      rd_q <= 1'b0;
      wr_q <= 1'b0;
      act_q <= 1'b0;
      ill_q <= 1'b0;
    end else if (CE) begin
      op_q <= op_d;
      addr_q <= addr_d;
      bit_q <= bit_d;
      data_q <= data_d;
      rd_q <= rd_d;
      wr_q <= wr_d;
      act_q <= act_d;
      ill_q <= ill_d;
    end
  end

  // Phase mirrored from a flop; one cycle behind the sequencer on purpose
  logic [1:0] phase_out_q, phase_out_d;
  always_comb begin
    phase_out_d = phase;
  end

  // Phase mirror register, frozen with the rest of the state
  always_ff @(posedge REF_CLK or negedge RSTN) begin
    if (!RSTN) begin
      phase_out_q <= 2'h0;
    end else if (CE) begin
      phase_out_q <= phase_out_d;
    end
  end

  assign PHASE = phase_out_q;
  assign MEM_ADDR = addr_q;
  assign MEM_RD = rd_q;
  assign MEM_WR = wr_q;
  assign MEM_WDATA = data_q;
  assign OP_ACTIVE = act_q;
  assign OP_ILLEGAL = ill_q;

  // Bit set writes read byte with one bit forced
  a_setb_result: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CE && phase == IOBF_Q3 && op_q == IOBF_SETB
      |=> MEM_WR && MEM_WDATA == ($past(data_q) | (8'h01 << $past(bit_q))))
    else $error("bit set wrote wrong byte");

  a_fill_ones: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CE && phase == IOBF_Q3 && op_q == IOBF_FILL
      |=> MEM_WR && MEM_WDATA == IOBF_ONES)
    else $error("fill did not write ones");

  a_addr_sum: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CE && phase == IOBF_Q1 && INSTR_VALID
      |=> MEM_ADDR == $past(POINTER_REGISTER_TWO) + ADDR_W'($past(ofs)))
    else $error("target address wrong");

  a_ofs_range: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CE && phase == IOBF_Q1 && ofs > 8'(IOBF_OFS_MAX) |=> !OP_ACTIVE)
    else $error("offset above 95 accepted");

  a_ill_quiet: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    OP_ILLEGAL |-> !MEM_RD && !MEM_WR)
    else $error("refused operation strobed memory");

  a_bit_field: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    CE && phase == IOBF_Q1
      |=> bit_q == $past(INSTR_WORD[IOBF_BIT_MSB:IOBF_BIT_LSB]))
    else $error("bit select not captured");

  // Read then write two cycles apart within one instruction
  sequence s_read;
    MEM_RD && CE;
  endsequence
  sequence s_write;
    CE [*2] ##1 MEM_WR;
  endsequence
  a_four_phase: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    s_read |-> s_write)
    else $error("write back not in last phase");

  // Only the bit set reads its target
  a_fill_no_read: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    MEM_RD |-> op_q == IOBF_SETB)
    else $error("read strobe outside bit set");

  a_wr_phase: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    MEM_WR |-> phase == IOBF_Q4)
    else $error("write outside last phase");

  a_one_write: assert property (
    @(posedge REF_CLK) disable iff (!RSTN)
    MEM_WR && CE |=> !MEM_WR)
    else $error("double write");
endmodule // iobf_core

// >>> include/iobf_pkg.sv
// Constants and types for the indexed bit set and fill-ones decoder
//
// Operation
// - Offset is unsigned 0 to 95, added to the pointer for the address.
// - A three-bit field picks bit 0 through 7 of the target byte.
// - Opcode 1000 bbb0 sets the chosen bit; other bits and flags stay.
// - Opcode 0110 1000 writes FFh to pointer plus offset; flags stay.
package iobf_pkg;
  localparam int IOBF_ADDR_W = 12;
  localparam int IOBF_OFS_MAX = 95;
  localparam logic [3:0] IOBF_SETB_OP = 4'h8;
  localparam logic [7:0] IOBF_FILL_OP = 8'h68;
  localparam int IOBF_BIT_LSB = 9;
  localparam int IOBF_BIT_MSB = 11;
  localparam logic [7:0] IOBF_ONES = 8'hFF;
  localparam logic [7:0] IOBF_BYTE_RST = 8'h00;
  typedef enum logic [1:0] {IOBF_Q1, IOBF_Q2, IOBF_Q3, IOBF_Q4} iobf_phase_type;
  typedef enum logic [1:0] {IOBF_NONE, IOBF_SETB, IOBF_FILL} iobf_op_type;
endpackage

// >>> rtl/iobf_phase_gen.sv
// Four-phase instruction cycle sequencer
`timescale 1ns/100ps
module iobf_phase_gen
  import iobf_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ce,
  output iobf_phase_type phase
);
  iobf_phase_type phase_q, phase_d;

  // Phases advance in strict order, wrapping after write back
  always_comb begin
    case (phase_q)
      IOBF_Q1: phase_d = IOBF_Q2;
      IOBF_Q2: phase_d = IOBF_Q3;
      IOBF_Q3: phase_d = IOBF_Q4;
      default: phase_d = IOBF_Q1;
    endcase
  end

  // Phase register, frozen while the enable is low
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      phase_q <= IOBF_Q1;
    end else if (ce) begin
      phase_q <= phase_d;
    end
  end

  assign phase = phase_q;
endmodule // iobf_phase_gen

// >>> sim/iobf_mem_model.sv
// Byte-wide data memory model on the far side of the decoder
`timescale 1ns/100ps
module iobf_mem_model (
  input wire logic clk,
  input wire logic [11:0] addr,
  input wire logic rd,
  input wire logic wr,
  input wire logic [7:0] wdata,
  output logic [7:0] rdata
);
  logic [7:0] mem [0:4095];
  // Inverted data outside a read, so a stale capture shows
  assign rdata = rd ? mem[addr] : ~mem[addr];
  // Write lands at the edge that closes the strobe cycle
  always @(posedge clk) begin
    if (wr) mem[addr] <= wdata;
  end
endmodule // iobf_mem_model

// >>> sim/test_indexed_offset_bit_fill_ops.sv
// Self-checking bench for the indexed bit set and fill decoder
`timescale 1ns/100ps
module test_indexed_offset_bit_fill_ops;
  import iobf_pkg::*;
  logic clk = 0, rstn = 0, valid = 0, ce = 1, rd, wr, act, ill, ills;
  logic [15:0] word = 0;
  logic [11:0] ptr = 0, addr;
  logic [7:0] rdata, wdata, e;
  logic [1:0] phase;
  logic [2:0] nrd, nwr, nact;
  int error_cnt = 0, n_compared = 0;
  iobf_core dut (.REF_CLK(clk), .RSTN(rstn), .CE(ce),
    .INSTR_VALID(valid), .INSTR_WORD(word), .POINTER_REGISTER_TWO(ptr),
    .MEM_RDATA(rdata), .PHASE(phase), .MEM_ADDR(addr), .MEM_RD(rd),
    .MEM_WR(wr), .MEM_WDATA(wdata), .OP_ACTIVE(act), .OP_ILLEGAL(ill));
  iobf_mem_model mem_i (.clk(clk), .addr(addr), .rd(rd), .wr(wr),
    .wdata(wdata), .rdata(rdata));
  // 50 MHz clock
  initial begin
    forever #10 clk = ~clk;
  end
  task chk8(input logic [7:0] got, input logic [7:0] x);
    n_compared++;
    if (got !== x) begin
      error_cnt++;
      $display("unexpected at %0t: byte %h not %h", $time, got, x);
    end
  endtask
  task chk_cnt(input logic [2:0] got, input logic [2:0] x);
    n_compared++;
    if (got !== x) begin
      error_cnt++;
      $display("unexpected at %0t: count %h not %h", $time, got, x);
    end
  endtask
  task chk_phase(input logic [1:0] got, input logic [1:0] x);
    n_compared++;
    if (got !== x) begin
      error_cnt++;
      $display("unexpected at %0t: phase %h not %h", $time, got, x);
    end
  endtask
  // One full instruction cycle, strobes counted over its four phases
  task issue(input logic [15:0] w, input logic [11:0] p, input logic v);
    word = w;
    ptr = p;
    valid = v;
    nrd = 3'h0;
    nwr = 3'h0;
    nact = 3'h0;
    for (int k = 0; k < 4; k++) begin
      @(posedge clk);
      #1;
      nrd = nrd + {2'b0, rd};
      nwr = nwr + {2'b0, wr};
      nact = nact + {2'b0, act};
      ills = ill;
      chk_phase(phase, 2'(k));
    end
  endtask
  // Undecoded word between ops: no strobe and no activity at all
  task nop_check;
    issue(16'h0000, 12'hA00, 1'b1);
    chk_cnt(nrd + nwr + nact, 3'h0);
  endtask
  // Every bit at the top offset, some bits already set
  task set_bits;
    mem_i.mem[12'hA5F] = 8'h55;
    e = 8'h55;
    for (int b = 0; b < 8; b++) begin
      issue({IOBF_SETB_OP, 3'(b), 1'b0, 8'h5F}, 12'hA00, 1'b1);
      chk_cnt(nrd, 3'h1);
      chk_cnt(nwr, 3'h1);
      chk_cnt(nact, 3'h3);
      e[b] = 1'b1;
      nop_check();
      chk8(mem_i.mem[12'hA5F], e);
    end
  endtask
  // Fill writes only its own byte, no read
  task fill;
    mem_i.mem[12'hA2C] = 8'h00;
    mem_i.mem[12'hA2D] = 8'h5A;
    issue(16'h682C, 12'hA00, 1'b1);
    chk_cnt(nrd, 3'h0);
    chk_cnt(nact, 3'h3);
    chk_cnt(nwr, 3'h1);
    nop_check();
    chk8(mem_i.mem[12'hA2C], IOBF_ONES);
    chk8(mem_i.mem[12'hA2D], 8'h5A);
  endtask
  // Offset 96 is one past the range, both ops refused
  task bad_offset(input logic [15:0] w);
    mem_i.mem[12'hA60] = 8'h00;
    issue(w, 12'hA00, 1'b1);
    chk_cnt({2'b0, ills}, 3'h1);
    chk_cnt(nwr, 3'h0);
    chk_cnt(nact, 3'h0);
    nop_check();
    chk8(mem_i.mem[12'hA60], 8'h00);
  endtask
  // Valid low: a matching word is ignored
  task no_valid;
    mem_i.mem[12'hA30] = 8'h00;
    issue(16'h6830, 12'hA00, 1'b0);
    chk_cnt(nrd + nwr + nact, 3'h0);
    chk8(mem_i.mem[12'hA30], 8'h00);
  endtask
  // Enable low mid-instruction freezes every output and the phase
  task ce_freeze;
    mem_i.mem[12'hA20] = 8'h00;
    word = 16'h6820;
    ptr = 12'hA00;
    valid = 1'b1;
    @(posedge clk);
    #1;
    ce = 1'b0;
    repeat (3) @(posedge clk);
    #1;
    chk_cnt({rd, wr, act}, 3'h1);
    chk_phase(phase, 2'h0);
    chk8(mem_i.mem[12'hA20], 8'h00);
    ce = 1'b1;
    nwr = 3'h0;
    repeat (3) begin
      @(posedge clk);
      #1;
      nwr = nwr + {2'b0, wr};
    end
    chk_cnt(nwr, 3'h1);
    chk8(mem_i.mem[12'hA20], IOBF_ONES);
  endtask
  // Reset mid-instruction drops it; the next one starts from decode
  task reset_mid;
    mem_i.mem[12'hA10] = 8'h81;
    word = {IOBF_SETB_OP, 3'h6, 1'b0, 8'h10};
    ptr = 12'hA00;
    valid = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b0;
    #1;
    chk_cnt({rd, wr, act}, 3'h0);
    chk_phase(phase, 2'h0);
    chk8(wdata, IOBF_BYTE_RST);
    chk8(addr[7:0], 8'h00);
    repeat (2) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk8(mem_i.mem[12'hA10], 8'h81);
    issue(16'h6810, 12'hA00, 1'b1);
    chk_cnt(nwr, 3'h1);
    nop_check();
    chk8(mem_i.mem[12'hA10], IOBF_ONES);
  endtask
  task finish_test;
    $display("errors %0d compared %0d", error_cnt, n_compared);
    if (error_cnt == 0 && n_compared > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  // Reset for six cycles, then scenarios back to back
  initial begin
    repeat (6) @(posedge clk);
    #1;
    rstn = 1'b1;
    set_bits();
    fill();
    bad_offset(16'h8060);
    bad_offset(16'h6860);
    no_valid();
    ce_freeze();
    reset_mid();
    finish_test();
  end
  // Run needs about 117 cycles; far longer means a hang
  initial begin
    #20000;
    error_cnt++;
    finish_test();
  end
endmodule // test_indexed_offset_bit_fill_ops
